// *** pmc_pkg.sv ***
package pmc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SCC_OFF    = 8'h00;
  localparam logic [7:0] HIRCC_OFF  = 8'h04;
  localparam logic [7:0] HXTC_OFF   = 8'h08;
  localparam logic [7:0] LOW_SPEED_CRYSTAL_CONTROL_OFF   = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] PORT_A_WAKE_ENABLE_OFF   = 8'h14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int EN_BIT   = 0;
  localparam int FLAG_BIT = 1;
  localparam int AUX_BIT  = 2;
  localparam int FHS_BIT  = 3;
  localparam int FSS_BIT  = 2;
  localparam int FHI_BIT  = 1;
  localparam int FSI_BIT  = 0;
  localparam int CKS_LSB  = 5;
  localparam int FRQ_LSB  = 2;
  localparam int PDF_BIT  = 0;
  localparam int TO_BIT   = 1;

  localparam logic [2:0] CKS_SUB     = 3'h7;
  localparam logic [2:0] CKS_RST     = 3'h0;
  localparam logic [1:0] HS_INTERNAL_RC_FRQ_RST = 2'h0;
  localparam logic       HS_INTERNAL_RC_EN_RST = 1'b1;

  // oscillator index for the stable flag array
  localparam int OSC_N    = 3;
  localparam int OSC_HXT  = 0;
  localparam int OSC_HS_INTERNAL_RC = 1;
  localparam int OSC_LXT  = 2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HALT = 3'b010,
    ST_WAKE = 3'b100
  } pstate_e;

  // encoded as {hs keep, ls keep}
  typedef enum logic [1:0] {
    PM_SLEEP = 2'h0,
    PM_IDLE0 = 2'h1,
    PM_IDLE2 = 2'h2,
    PM_IDLE1 = 2'h3
  } pmode_e;

  typedef enum logic [1:0] {
    WK_PORT = 2'h0,
    WK_IRQ  = 2'h1,
    WK_WDT  = 2'h2
  } wake_e;

  typedef struct packed {
    logic [2:0] sysclk_select_field;
    logic       hs_select;
    logic       sub_clock_source_sel;
    logic       idle_hs_osc_keep;
    logic       idle_ls_osc_keep;
  } scc_s;

endpackage : pmc_pkg

// *** osc_ready_power_mode_ctrl.sv ***
// Our own choices: register access over AXI4-Lite and the register addresses.
module osc_ready_power_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int PA_W  = 8,
  parameter int IRQ_N = 4
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              halt_req,
  input  wire logic              clr_wdt_req,
  input  wire logic              wdt_enable,
  input  wire logic              wdt_overflow,
  input  wire logic [IRQ_N-1:0]  irq_req,
  input  wire logic [IRQ_N-1:0]  irq_enable,
  input  wire logic              stack_full,
  input  wire logic [PA_W-1:0]   port_a,
  input  wire logic [OSC_N-1:0]  osc_ready,
  input  wire logic              ls_rc_ready,
  output logic                   hs_crystal_on,
  output logic                   hs_rc_on,
  output logic                   ls_crystal_on,
  output logic                   ls_rc_on,
  output logic                   ls_crystal_speedup,
  output logic                   hs_crystal_fast_mode,
  output logic [1:0]             hs_rc_freq_sel,
  output logic [2:0]             sysclk_div,
  output logic                   sysclk_from_sub,
  output logic                   cpu_run,
  output logic [1:0]             power_mode,
  output logic                   wdt_clear,
  output logic                   pc_sp_reset,
  output logic                   resume_next,
  output logic                   irq_respond,
  output logic                   power_down_flag,
  output logic                   watchdog_timeout_flag
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  scc_s             scc_r;
  logic [1:0]       hs_internal_rc_frq_r;
  logic [OSC_N-1:0] osc_en_r;
  logic [OSC_N-1:0] stable_r;
  logic [OSC_N-1:0] restart;
  logic [OSC_N-1:0] osc_on;
  logic             hxt_mode_r;
  logic             lxt_sp_r;
  logic [PA_W-1:0]  port_a_wake_enable_r;
  logic             pdf_r;
  logic             to_r;
  pstate_e          state_r;
  pmode_e           mode_r;
  wake_e            cause_r;
  logic             irq_serve_r;
  logic [IRQ_N-1:0] irq_armed_r;
  logic [PA_W-1:0]  pa_prev_r;
  logic             from_sub_r;
  logic [2:0]       div_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;
  logic [1:0]       bresp_r;
  logic             bvalid_r;
  logic             rvalid_r;
  logic [4:0]       pulse_r;

  logic       wr_go;
  logic       wr_lo;
  logic [7:0] wb;
  logic       rd_go;
  logic       halt_go;
  logic       halted;
  logic       hs_gate;
  logic       ls_gate;
  logic       hs_stable;
  logic       sub_stable;
  logic       sys_stable;
  logic       pa_fall;
  logic       irq_wake;
  logic       irq_ok;
  logic       wake_go;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  assign awready = awvalid && wvalid && !bvalid_r;
  assign wready  = awready;
  assign wr_go   = awready;
  assign wr_lo   = wr_go && wstrb[0];
  assign wb      = wdata[7:0];
  assign arready = !rvalid_r;
  assign rd_go   = arvalid && arready;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr <= PORT_A_WAKE_ENABLE_OFF && awaddr[1:0] == 2'h0)
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
      case (araddr)
        SCC_OFF:
          rdata_r[7:0] <= {scc_r.sysclk_select_field, 1'b0,
                           scc_r.hs_select, scc_r.sub_clock_source_sel,
                           scc_r.idle_hs_osc_keep, scc_r.idle_ls_osc_keep};
        HIRCC_OFF:
          rdata_r[3:0] <= {hs_internal_rc_frq_r, stable_r[OSC_HS_INTERNAL_RC], osc_en_r[OSC_HS_INTERNAL_RC]};
        HXTC_OFF:
          rdata_r[2:0] <= {hxt_mode_r, stable_r[OSC_HXT], osc_en_r[OSC_HXT]};
        LOW_SPEED_CRYSTAL_CONTROL_OFF:
          rdata_r[2:0] <= {lxt_sp_r, stable_r[OSC_LXT], osc_en_r[OSC_LXT]};
        STATUS_OFF: begin
          rdata_r[PDF_BIT] <= pdf_r;
          rdata_r[TO_BIT]  <= to_r;
        end
        PORT_A_WAKE_ENABLE_OFF:
          rdata_r[PA_W-1:0] <= port_a_wake_enable_r;
        default:
          rresp_r <= RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // registers only change by writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scc_r      <= '{CKS_RST, 1'b0, 1'b0, 1'b0, 1'b0};
      hs_internal_rc_frq_r <= HS_INTERNAL_RC_FRQ_RST;
      osc_en_r   <= {1'b0, HS_INTERNAL_RC_EN_RST, 1'b0};
      hxt_mode_r <= 1'b0;
      lxt_sp_r   <= 1'b0;
      port_a_wake_enable_r <= '0;
    end else if (wr_lo) begin
      case (awaddr)
        SCC_OFF:
          scc_r <= '{wb[CKS_LSB +: 3], wb[FHS_BIT], wb[FSS_BIT],
                     wb[FHI_BIT], wb[FSI_BIT]};
        HIRCC_OFF: begin
          hs_internal_rc_frq_r         <= wb[FRQ_LSB +: 2];
          osc_en_r[OSC_HS_INTERNAL_RC] <= wb[EN_BIT];
        end
        HXTC_OFF: begin
          if (!osc_en_r[OSC_HXT])
            hxt_mode_r <= wb[AUX_BIT];
          osc_en_r[OSC_HXT] <= wb[EN_BIT];
        end
        LOW_SPEED_CRYSTAL_CONTROL_OFF: begin
          lxt_sp_r          <= wb[AUX_BIT];
          osc_en_r[OSC_LXT] <= wb[EN_BIT];
        end
        PORT_A_WAKE_ENABLE_OFF:
          port_a_wake_enable_r <= wdata[PA_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // oscillator gating and stable flags
  // ---------------------------------------------------------------
  assign halted  = (state_r == ST_HALT);
  assign hs_gate = !halted || scc_r.idle_hs_osc_keep;
  assign ls_gate = !halted || scc_r.idle_ls_osc_keep;

  assign osc_on[OSC_HXT]  = osc_en_r[OSC_HXT] && hs_gate;
  assign osc_on[OSC_HS_INTERNAL_RC] = osc_en_r[OSC_HS_INTERNAL_RC] && hs_gate;
  assign osc_on[OSC_LXT]  = osc_en_r[OSC_LXT] && ls_gate;

  assign restart[OSC_HXT] = wr_lo && awaddr == HXTC_OFF && wb[EN_BIT]
                            && !osc_en_r[OSC_HXT];
  assign restart[OSC_HS_INTERNAL_RC] = wr_lo && awaddr == HIRCC_OFF && wb[EN_BIT]
                             && (!osc_en_r[OSC_HS_INTERNAL_RC]
                                 || wb[FRQ_LSB +: 2] != hs_internal_rc_frq_r);
  assign restart[OSC_LXT] = wr_lo && awaddr == LOW_SPEED_CRYSTAL_CONTROL_OFF && wb[EN_BIT]
                            && !osc_en_r[OSC_LXT];

  generate
    for (genvar i = 0; i < OSC_N; i++) begin : g_flag
      // clear on enable, set when stable
      always_ff @(posedge aclk) begin
        if (!aresetn)
          stable_r[i] <= 1'b0;
        else if (!osc_on[i] || restart[i])
          stable_r[i] <= 1'b0;
        else if (osc_ready[i])
          stable_r[i] <= 1'b1;
      end
    end
  endgenerate

  assign hs_crystal_on        = osc_on[OSC_HXT];
  assign hs_rc_on             = osc_on[OSC_HS_INTERNAL_RC];
  assign ls_crystal_on        = osc_on[OSC_LXT];
  // watchdog keeps the low rc alive
  assign ls_rc_on             = ls_gate || wdt_enable;
  assign ls_crystal_speedup   = lxt_sp_r;
  assign hs_crystal_fast_mode = hxt_mode_r;
  assign hs_rc_freq_sel       = hs_internal_rc_frq_r;

  // ---------------------------------------------------------------
  // system clock switching
  // ---------------------------------------------------------------
  assign hs_stable  = scc_r.hs_select ? stable_r[OSC_HXT]
                                      : stable_r[OSC_HS_INTERNAL_RC];
  assign sub_stable = scc_r.sub_clock_source_sel ? stable_r[OSC_LXT]
                                                 : ls_rc_ready;
  assign sys_stable = from_sub_r ? sub_stable : hs_stable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      from_sub_r <= 1'b0;
      div_r      <= CKS_RST;
    end else if (scc_r.sysclk_select_field == CKS_SUB) begin
      // slow entry once sub source stable
      if (sub_stable)
        from_sub_r <= 1'b1;
    end else if (!from_sub_r || hs_stable) begin
      from_sub_r <= 1'b0;
      div_r      <= scc_r.sysclk_select_field;
    end
  end

  assign sysclk_div      = div_r;
  assign sysclk_from_sub = from_sub_r;

  // ---------------------------------------------------------------
  // halt and wake sequencing
  // ---------------------------------------------------------------
  assign halt_go  = (state_r == ST_RUN) && halt_req;
  assign pa_fall  = |(pa_prev_r & ~port_a & port_a_wake_enable_r);
  assign irq_wake = |(irq_req & irq_armed_r);
  assign irq_ok   = |(irq_req & irq_armed_r & irq_enable) && !stack_full;
  assign wake_go  = halted && (wdt_overflow || irq_wake || pa_fall);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      pa_prev_r <= '0;
    else
      pa_prev_r <= port_a;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= ST_RUN;
      mode_r      <= PM_SLEEP;
      cause_r     <= WK_PORT;
      irq_serve_r <= 1'b0;
      irq_armed_r <= '0;
    end else begin
      case (state_r)
        ST_RUN:
          if (halt_go) begin
            mode_r      <= pmode_e'({scc_r.idle_hs_osc_keep,
                                     scc_r.idle_ls_osc_keep});
            irq_armed_r <= ~irq_req;
            state_r     <= ST_HALT;
          end
        ST_HALT:
          if (wake_go) begin
            cause_r     <= wdt_overflow ? WK_WDT
                           : irq_wake ? WK_IRQ : WK_PORT;
            irq_serve_r <= !wdt_overflow && irq_ok;
            state_r     <= ST_WAKE;
          end
        ST_WAKE:
          if (sys_stable)
            state_r <= ST_RUN;
        default:
          state_r <= ST_RUN;
      endcase
    end
  end

  // pulses: wdt clear, pc/sp reset, resume next, irq respond
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_r <= '0;
    end else begin
      pulse_r[0] <= halt_go;
      // overflow resets pc and sp only
      pulse_r[1] <= state_r == ST_WAKE && sys_stable && cause_r == WK_WDT;
      pulse_r[2] <= state_r == ST_WAKE && sys_stable && cause_r != WK_WDT
                    && !(cause_r == WK_IRQ && irq_serve_r);
      pulse_r[3] <= state_r == ST_WAKE && sys_stable && cause_r == WK_IRQ
                    && irq_serve_r;
      pulse_r[4] <= 1'b0;
    end
  end

  assign wdt_clear   = pulse_r[0];
  assign pc_sp_reset = pulse_r[1];
  assign resume_next = pulse_r[2];
  assign irq_respond = pulse_r[3];
  assign cpu_run     = (state_r == ST_RUN);
  assign power_mode  = mode_r;

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pdf_r <= 1'b0;
    else if (halt_go)
      pdf_r <= 1'b1;
    else if (clr_wdt_req)
      pdf_r <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      to_r <= 1'b0;
    else if (wdt_overflow)
      to_r <= 1'b1;
    else if (halt_go)
      to_r <= 1'b0;
  end

  assign power_down_flag       = pdf_r;
  assign watchdog_timeout_flag = to_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence halt_entry_s;
    halt_go ##1 halted;
  endsequence

  flag_restart_a: assert property (
    restart[OSC_LXT] |=> !stable_r[OSC_LXT])
    else $error("stable flag not cleared on enable");
  osc_off_a: assert property (
    !osc_en_r[OSC_HXT] |-> !hs_crystal_on ##1 !stable_r[OSC_HXT])
    else $error("stable flag kept while oscillator off");
  slow_entry_a: assert property (
    $rose(from_sub_r) |-> $past(sub_stable)
                          && $past(scc_r.sysclk_select_field) == CKS_SUB)
    else $error("slow switch before sub source stable");
  normal_return_a: assert property (
    $fell(from_sub_r) |-> $past(hs_stable))
    else $error("normal return before high clock stable");
  halt_flags_a: assert property (
    halt_entry_s |-> pdf_r && wdt_clear)
    else $error("halt did not set power-down flag");
  sleep_clocks_a: assert property (
    halted && mode_r == PM_SLEEP
      |-> !hs_crystal_on && !hs_rc_on && !ls_crystal_on)
    else $error("clock running in sleep");
  idle1_clocks_a: assert property (
    halted && mode_r == PM_IDLE1
      |-> ls_rc_on && hs_rc_on == osc_en_r[OSC_HS_INTERNAL_RC])
    else $error("idle1 clock stopped");
  rc_watchdog_a: assert property (
    wdt_enable |-> ls_rc_on)
    else $error("low rc off with watchdog enabled");
  wake_hold_a: assert property (
    state_r == ST_WAKE && !sys_stable |=> !cpu_run)
    else $error("execution resumed before oscillator stable");
  stale_irq_a: assert property (
    halted && !wdt_overflow && !pa_fall && !(|(irq_req & irq_armed_r))
      |=> halted)
    else $error("woken by stale request");

endmodule : osc_ready_power_mode_ctrl

// *** core_model.sv ***
module core_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cpu_run,
  input  wire logic halt_cmd,
  output logic      halt_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // halt issue
  // ---------------------------------------------------------------
  // one-cycle halt, only from a running core
  always @(posedge aclk) begin
    if (!aresetn) begin
      halt_req <= 1'b0;
    end else begin
      halt_req <= halt_cmd & cpu_run & ~halt_req;
    end
  end
endmodule : core_model

// *** test_osc_ready_power_mode_ctrl.sv ***
module test_osc_ready_power_mode_ctrl
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, halt_req, halt_cmd, clr_wdt_req;
  logic wdt_enable, wdt_overflow, stack_full, ls_rc_ready, clr_seen;
  logic hs_crystal_on, hs_rc_on, ls_crystal_on, ls_rc_on, ls_crystal_speedup;
  logic hs_crystal_fast_mode, sysclk_from_sub, cpu_run, wdt_clear;
  logic pc_sp_reset, resume_next, irq_respond, power_down_flag;
  logic watchdog_timeout_flag;
  logic [7:0]  awaddr, araddr, port_a, a;
  logic [31:0] wdata, rdata, ev;
  logic [3:0]  wstrb, irq_req, irq_enable, seen;
  logic [1:0]  bresp, rresp, hs_rc_freq_sel, power_mode;
  logic [2:0]  osc_ready, sysclk_div;
  int          errors, checked, cycles, m, k, pin;

  osc_ready_power_mode_ctrl #(.PA_W(8), .IRQ_N(4)) uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .halt_req, .clr_wdt_req, .wdt_enable,
    .wdt_overflow, .irq_req, .irq_enable, .stack_full, .port_a, .osc_ready,
    .ls_rc_ready, .hs_crystal_on, .hs_rc_on, .ls_crystal_on, .ls_rc_on,
    .ls_crystal_speedup, .hs_crystal_fast_mode, .hs_rc_freq_sel,
    .sysclk_div, .sysclk_from_sub, .cpu_run, .power_mode, .wdt_clear,
    .pc_sp_reset, .resume_next, .irq_respond, .power_down_flag,
    .watchdog_timeout_flag
  );
  core_model core (.aclk, .aresetn, .cpu_run, .halt_cmd, .halt_req);

  // ---------------------------------------------------------------
  // clock, pulse capture, hang limit
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (clr_seen || !aresetn) seen <= 4'h0;
    else seen <= seen | {irq_respond, resume_next, pc_sp_reset, wdt_clear};
    if (cycles == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input logic [1:0] er);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask : rd
  task automatic run_wait(input logic v);
    for (int n = 0; n < 100 && cpu_run !== v; n++) @(posedge aclk);
    chk("cpu_run", v, cpu_run);
  endtask : run_wait
  task automatic do_halt(input logic [1:0] md);
    wr(SCC_OFF, {30'h0, md}, RESP_OKAY);
    halt_cmd <= 1'b1;
    clr_seen <= 1'b1;
    @(posedge aclk);
    halt_cmd <= 1'b0;
    clr_seen <= 1'b0;
    run_wait(1'b0);
    chk("mode", md, power_mode);
    chk("hs_on", md[1], hs_rc_on);
    chk("ls_on", md[0] | wdt_enable, ls_rc_on);
    chk("pdf", 1, power_down_flag);
    chk("to", 0, watchdog_timeout_flag);
  endtask : do_halt
  task automatic woke(input logic [3:0] ex);
    run_wait(1'b1);
    @(posedge aclk);
    chk("pulses", ex, seen);
    chk("pdf", 1, power_down_flag);
  endtask : woke

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, halt_cmd} = '0;
    {clr_wdt_req, wdt_enable, wdt_overflow, stack_full, clr_seen} = '0;
    {awaddr, araddr, wdata, irq_req, irq_enable} = '0;
    wstrb = 4'hf;
    port_a = 8'hff;
    osc_ready = 3'h2;
    ls_rc_ready = 1'b1;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    k = $urandom(72);
    rd(SCC_OFF, 32'h0, RESP_OKAY);
    rd(HIRCC_OFF, 32'h3, RESP_OKAY);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'hff, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(SCC_OFF, 32'hff, RESP_OKAY);
    wstrb <= 4'hf;
    rd(SCC_OFF, 32'h0, RESP_OKAY);
    wr(HIRCC_OFF, 32'h9, RESP_OKAY);
    rd(HIRCC_OFF, 32'hb, RESP_OKAY);
    chk("frq", 2, hs_rc_freq_sel);
    wr(HIRCC_OFF, 32'h1, RESP_OKAY);
    wr(HXTC_OFF, 32'h5, RESP_OKAY);
    wr(HXTC_OFF, 32'h1, RESP_OKAY);
    chk("hxt_mode", 1, hs_crystal_fast_mode);
    wr(HXTC_OFF, 32'h0, RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      a = k ? LOW_SPEED_CRYSTAL_CONTROL_OFF : HXTC_OFF;
      ev = k ? 32'h5 : 32'h1;
      wr(a, ev | 32'hf8, RESP_OKAY);
      rd(a, ev, RESP_OKAY);
      chk("x_on", 1, k ? ls_crystal_on : hs_crystal_on);
      chk("speedup", k, ls_crystal_speedup);
      osc_ready[k*2] <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(a, ev | 32'h2, RESP_OKAY);
      wr(a, 32'h0, RESP_OKAY);
      rd(a, 32'h0, RESP_OKAY);
      chk("x_off", 0, k ? ls_crystal_on : hs_crystal_on);
    end
    wr(LOW_SPEED_CRYSTAL_CONTROL_OFF, 32'h1, RESP_OKAY);
    for (k = 0; k < 7; k++) begin
      osc_ready[2] <= 1'b0;
      ls_rc_ready <= 1'b0;
      // restart the crystal so its flag must rise again
      wr(LOW_SPEED_CRYSTAL_CONTROL_OFF, 32'h0, RESP_OKAY);
      wr(LOW_SPEED_CRYSTAL_CONTROL_OFF, 32'h1, RESP_OKAY);
      wr(SCC_OFF, {24'h0, 3'h7, 2'h0, k[0], 2'h0}, RESP_OKAY);
      repeat (10) @(posedge aclk);
      chk("from_sub", 0, sysclk_from_sub);
      osc_ready[2] <= 1'b1;
      ls_rc_ready <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("from_sub", 1, sysclk_from_sub);
      wr(SCC_OFF, {24'h0, k[2:0], 5'h0}, RESP_OKAY);
      rd(HIRCC_OFF, 32'h3, RESP_OKAY);
      repeat (10) @(posedge aclk);
      chk("from_sub", 0, sysclk_from_sub);
      chk("div", k, sysclk_div);
    end
    for (m = 0; m < 4; m++) begin
      do_halt(m[1:0]);
      case (m)
        0: begin
          pin = $urandom % 8;
          wr(PORT_A_WAKE_ENABLE_OFF, 32'h1 << pin, RESP_OKAY);
          port_a[3'(pin + 1)] <= 1'b0;
          repeat (10) @(posedge aclk);
          chk("cpu_run", 0, cpu_run);
          osc_ready[1] <= 1'b0;
          port_a[pin[2:0]] <= 1'b0;
          repeat (10) @(posedge aclk);
          chk("cpu_run", 0, cpu_run);
          osc_ready[1] <= 1'b1;
          woke(4'b0101);
          port_a <= 8'hff;
        end
        1: begin
          wdt_overflow <= 1'b1;
          @(posedge aclk);
          wdt_overflow <= 1'b0;
          woke(4'b0011);
          chk("to", 1, watchdog_timeout_flag);
        end
        2: begin
          k = $urandom % 4;
          irq_enable <= 4'h1 << k;
          irq_req <= 4'h1 << k;
          woke(4'b1001);
        end
        default: begin
          repeat (20) @(posedge aclk);
          chk("cpu_run", 0, cpu_run);
          irq_req <= irq_req | (4'h1 << ((k + 1) % 4));
          woke(4'b0101);
          irq_req <= 4'h0;
        end
      endcase
      rd(SCC_OFF, m, RESP_OKAY);
    end
    wdt_enable <= 1'b1;
    do_halt(2'h0);
    wdt_overflow <= 1'b1;
    @(posedge aclk);
    wdt_overflow <= 1'b0;
    woke(4'b0011);
    clr_wdt_req <= 1'b1;
    @(posedge aclk);
    clr_wdt_req <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("pdf", 0, power_down_flag);
    rd(STATUS_OFF, 32'h2, RESP_OKAY);
    end_sim();
  end
endmodule : test_osc_ready_power_mode_ctrl
